/* src/harm_oc_stages.sv */
// four harmonic overcurrent stages behind an ahb-lite register slave
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module harm_oc_stages
  import harm_oc_pkg::*;
#(
  parameter int LOG_ENTRIES = LOG_DEPTH
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // measurement front end, one strobe per program cycle
  input  wire logic                 cycleTick,
  input  wire meas_t                meas,
  input  wire logic                 blockIn,
  input  wire logic [31:0]          timeStamp,
  input  wire logic [2:0]           settingGroup,
  // stage outputs
  output logic      [NUM_STAGES-1:0] startOut,
  output logic      [NUM_STAGES-1:0] tripOut,
  output logic      [NUM_STAGES-1:0] blockedOut,
  output logic      [NUM_STAGES-1:0] hmiNotify,
  output event_t    [NUM_STAGES-1:0] events
);

  typedef struct packed {
    stage_t [NUM_STAGES-1:0] stg;
    event_t [NUM_STAGES-1:0] evt;
    logic   [31:0]           rdata;
    logic                    ready;
    logic                    wrPend;
    logic   [7:0]            wrAddr;
    logic   [5:0]            histPtr;
  } state_t;

  state_t                  st_q;
  state_t                  st_d;
  logic   [15:0]           histMem [64];
  record_t                 logMem  [NUM_STAGES][LOG_ENTRIES];
  logic   [NUM_STAGES-1:0] logWr, overV, relV;
  record_t [NUM_STAGES-1:0] recV;
  logic   [2:0]            ftV [NUM_STAGES];
  logic   [23:0]           ratioV [NUM_STAGES], tgtV [NUM_STAGES];
  logic   [15:0]           maxHarm, pre20, pre200;
  logic   [31:0]           rdWord;

  //--------------------------------------------------------------
  // history of the largest phase harmonic
  //--------------------------------------------------------------
  always_comb begin
    logic [17:0] sum;
    sum = '0;
    maxHarm = meas.harm[0];
    for (int p = 1; p < 3; p++) begin
      if (meas.harm[p] > maxHarm) begin
        maxHarm = meas.harm[p];
      end
    end
    for (int k = 0; k < PRE_AVG_CYC; k++) begin
      sum = sum + 18'(histMem[6'(st_q.histPtr - 6'(PRE_AVG_CYC + k))]);
    end
    pre20 = 16'(sum / 18'(PRE_AVG_CYC));
    pre200 = histMem[6'(st_q.histPtr - 6'(PRE_HIST_CYC))];
  end

  //--------------------------------------------------------------
  // per-stage comparison and delay target
  //--------------------------------------------------------------
  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    always_comb begin
      logic [31:0] m, r, thr, rmax, q;
      m = '0;
      r = '0;
      rmax = '0;
      q = '0;
      thr = st_q.stg[s].rel ? 32'(st_q.stg[s].thrPct) : 32'(st_q.stg[s].thrPu);
      overV[s] = 1'b0;
      relV[s] = 1'b1;
      ftV[s] = '0;
      for (int p = 0; p < 3; p++) begin
        if (!st_q.stg[s].rel) begin
          m = 32'(meas.harm[p]);
        end else if (meas.fund[p] == 16'h0000) begin
          m = 32'(SAT24);
        end else begin
          m = (32'(meas.harm[p]) * PCT_SCALE) / 32'(meas.fund[p]);
        end
        m = (m > 32'(SAT24)) ? 32'(SAT24) : m;
        r = (m * RATIO_SCALE) / thr;
        rmax = (r > rmax) ? r : rmax;
        if (m > thr) begin
          overV[s] = 1'b1;
          ftV[s][p] = 1'b1;
        end
        if (m * RATIO_SCALE >= thr * RESET_RATIO) begin
          relV[s] = 1'b0;
        end
      end
      ratioV[s] = (rmax > 32'(SAT24)) ? SAT24 : rmax[23:0];
      if (st_q.stg[s].inv && rmax > RATIO_SCALE) begin
        q = (32'(st_q.stg[s].delay) * RATIO_SCALE) / (rmax - RATIO_SCALE);
        tgtV[s] = (q > 32'(SAT24)) ? SAT24 : q[23:0];
      end else begin
        tgtV[s] = st_q.stg[s].delay;
      end
    end
  end

  //--------------------------------------------------------------
  // register read decode
  //--------------------------------------------------------------
  always_comb begin
    stage_t  g;
    record_t rc;
    int      k;
    g = st_q.stg[haddr[STAGE_SHIFT+1:STAGE_SHIFT]];
    k = int'(g.logPtr) + LOG_ENTRIES - 1 - int'(g.logSel);
    k = (k >= LOG_ENTRIES) ? k - LOG_ENTRIES : k;
    rc = logMem[haddr[STAGE_SHIFT+1:STAGE_SHIFT]][k];
    rdWord = '0;
    if (haddr[31:8] == 24'h00_0000) begin
      case (haddr[5:0])
        OFS_CTRL:      rdWord = {21'h0, g.evtOff, g.evtOn, g.inv, g.rel, g.mode};
        OFS_THR_PU:    rdWord = {16'h0, g.thrPu};
        OFS_THR_PCT:   rdWord = {16'h0, g.thrPct};
        OFS_DELAY:     rdWord = {8'h0, g.delay};
        OFS_STATUS:    rdWord = {20'h0, g.faultType, g.blocked, g.trip, g.start, g.pickup,
                                 g.mode, g.cond};
        OFS_RATIO:     rdWord = {8'h0, g.ratio};
        OFS_REMAIN:    rdWord = {{8{g.remain[23]}}, g.remain};
        OFS_LOG_SEL:   rdWord = {24'h0, g.logCount, g.logSel};
        OFS_LOG_STAMP: rdWord = rc.stamp;
        OFS_LOG_INFO:  rdWord = {24'h0, rc.sg, rc.faultType, rc.sig};
        OFS_LOG_CURR:  rdWord = {rc.pre20, rc.fault};
        OFS_LOG_PRE:   rdWord = {16'h0, rc.pre200};
        OFS_LOG_REM:   rdWord = {{8{rc.remain[23]}}, rc.remain};
        default:       rdWord = '0;
      endcase
    end
  end

  //--------------------------------------------------------------
  // next state
  //--------------------------------------------------------------
  always_comb begin
    stage_t             g;
    logic               blk, off, pk;
    logic [2:0]         cur, prv, rise, fall;
    logic [23:0]        tmr;
    logic signed [31:0] rem;
    int                 sel, ws;
    g = '0;
    blk = 1'b0;
    off = 1'b0;
    pk = 1'b0;
    cur = '0;
    prv = '0;
    rise = '0;
    fall = '0;
    tmr = '0;
    rem = '0;
    sel = 0;
    ws = 0;
    st_d = st_q;
    logWr = '0;
    for (int s = 0; s < NUM_STAGES; s++) begin
      g = st_q.stg[s];
      recV[s] = '0;
      st_d.evt[s] = '0;
      if (g.pend != 6'h00) begin
        sel = 0;
        for (int i = 5; i >= 0; i--) begin
          if (g.pend[i]) begin
            sel = i;
          end
        end
        st_d.evt[s].valid = 1'b1;
        st_d.evt[s].stageId = 2'(s);
        st_d.evt[s].sig = 2'(sel % 3);
        st_d.evt[s].on = (sel < 3);
        st_d.evt[s].stamp = g.evtStamp;
        st_d.evt[s].data = g.evtData;
        g.pend[sel] = 1'b0;
      end
      g.notify = 1'b0;
      blk = blockIn || g.mode == BEH_BLOCKED || g.mode == BEH_TESTBLK;
      off = (g.mode == BEH_OFF);
      if (cycleTick) begin
        pk = off ? 1'b0 : overV[s] ? 1'b1 : relV[s] ? 1'b0 : g.pickup;
        if (pk && !g.pickup) begin
          g.faultType = ftV[s];
        end
        cur[0] = pk && !blk;
        cur[2] = pk && blk;
        tmr = !cur[0] ? 24'h00_0000 : !g.start ? 24'h00_0000 :
              (g.timer == SAT24) ? SAT24 : g.timer + 24'h00_0001;
        cur[1] = cur[0] && (tmr >= tgtV[s]);
        rem = $signed({8'h00, tgtV[s]}) - $signed({8'h00, tmr});
        rem = (rem > REMAIN_LIMIT) ? REMAIN_LIMIT : rem;
        rem = (rem < -REMAIN_LIMIT) ? -REMAIN_LIMIT : rem;
        g.remain = cur[0] ? 24'(rem) : 24'h00_0000;
        prv = {g.blocked, g.trip, g.start};
        rise = cur & ~prv;
        fall = ~cur & prv;
        g.pend = g.pend | {fall & g.evtOff, rise & g.evtOn};
        if (rise != 3'h0 || fall != 3'h0) begin
          g.evtStamp = timeStamp;
          g.evtData = maxHarm;
        end
        g.notify = rise[2];
        if (rise != 3'h0) begin
          logWr[s] = 1'b1;
          recV[s].stamp = timeStamp;
          recV[s].sig = rise[1] ? SIG_TRIP : rise[2] ? SIG_BLOCK : SIG_START;
          recV[s].faultType = g.faultType;
          recV[s].sg = settingGroup;
          recV[s].pre20 = pre20;
          recV[s].fault = maxHarm;
          recV[s].pre200 = pre200;
          recV[s].remain = g.remain;
          g.logPtr = (int'(g.logPtr) == LOG_ENTRIES - 1) ? 4'h0 : g.logPtr + 4'h1;
          if (int'(g.logCount) < LOG_ENTRIES) begin
            g.logCount = g.logCount + 4'h1;
          end
        end
        g.pickup = pk;
        g.start = cur[0];
        g.trip = cur[1];
        g.blocked = cur[2];
        g.timer = tmr;
        g.target = tgtV[s];
        g.ratio = ratioV[s];
        g.cond = cur[1] ? COND_TRIP : cur[2] ? COND_BLOCKED : cur[0] ? COND_START : COND_NORMAL;
      end
      st_d.stg[s] = g;
    end
    if (cycleTick) begin
      st_d.histPtr = st_q.histPtr + 6'h01;
    end
    // bus address phase
    st_d.wrPend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      st_d.wrPend = hwrite && (hsize == 3'h2) && (haddr[31:8] == 24'h00_0000);
      st_d.wrAddr = haddr[7:0];
      if (!hwrite) begin
        st_d.rdata = rdWord;
      end
    end
    // bus data phase
    if (st_q.wrPend) begin
      ws = int'(st_q.wrAddr[STAGE_SHIFT+1:STAGE_SHIFT]);
      g = st_d.stg[ws];
      case (st_q.wrAddr[5:0])
        OFS_CTRL: begin
          if (hwdata[2:0] >= BEH_ON && hwdata[2:0] <= BEH_OFF) begin
            g.mode = hwdata[2:0];
          end
          g.rel = hwdata[3];
          g.inv = hwdata[4];
          g.evtOn = hwdata[7:5];
          g.evtOff = hwdata[10:8];
        end
        OFS_THR_PU: begin
          g.thrPu = (hwdata[15:0] < PU_MIN || hwdata[31:16] != 16'h0) ?
                    ((hwdata[31:16] != 16'h0) ? PU_MAX : PU_MIN) :
                    (hwdata[15:0] > PU_MAX ? PU_MAX : hwdata[15:0]);
        end
        OFS_THR_PCT: begin
          g.thrPct = (hwdata[15:0] < PCT_MIN || hwdata[31:16] != 16'h0) ?
                     ((hwdata[31:16] != 16'h0) ? PCT_MAX : PCT_MIN) :
                     (hwdata[15:0] > PCT_MAX ? PCT_MAX : hwdata[15:0]);
        end
        OFS_DELAY: g.delay = hwdata[23:0];
        OFS_LOG_SEL: begin
          g.logSel = (int'(hwdata[3:0]) < LOG_ENTRIES) ? hwdata[3:0] : 4'(LOG_ENTRIES - 1);
        end
        default: g.logSel = g.logSel;
      endcase
      st_d.stg[ws] = g;
    end
  end

  //--------------------------------------------------------------
  // registers and memories
  //--------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.ready <= 1'b1;
      for (int s = 0; s < NUM_STAGES; s++) begin
        st_q.stg[s].mode <= BEH_ON;
        st_q.stg[s].evtOn <= 3'h7;
        st_q.stg[s].evtOff <= 3'h7;
        st_q.stg[s].thrPu <= PU_DEF;
        st_q.stg[s].thrPct <= PCT_DEF;
        st_q.stg[s].delay <= DELAY_DEF;
      end
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cycleTick) begin
      histMem[st_q.histPtr] <= maxHarm;
    end
    for (int s = 0; s < NUM_STAGES; s++) begin
      if (logWr[s]) begin
        logMem[s][st_q.stg[s].logPtr] <= recV[s];
      end
    end
  end

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  assign hrdata = st_q.rdata;
  assign hreadyout = st_q.ready;
  assign hresp = 1'b0;
  assign events = st_q.evt;
  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_out
    assign startOut[s] = st_q.stg[s].start;
    assign tripOut[s] = st_q.stg[s].trip;
    assign blockedOut[s] = st_q.stg[s].blocked;
    assign hmiNotify[s] = st_q.stg[s].notify;
  end

  //--------------------------------------------------------------
  // assertions on stage 0
  //--------------------------------------------------------------
  logic blk0;
  logic off0;
  assign blk0 = blockIn || st_q.stg[0].mode == BEH_BLOCKED || st_q.stg[0].mode == BEH_TESTBLK;
  assign off0 = (st_q.stg[0].mode == BEH_OFF);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_pickup_rise: assert property (cycleTick && overV[0] && !off0 |=> st_q.stg[0].pickup)
    else $error("pick-up missed an over-threshold phase");
  chk_pickup_hyst: assert property (cycleTick && st_q.stg[0].pickup && !relV[0] && !off0
    |=> st_q.stg[0].pickup)
    else $error("pick-up dropped above the reset ratio");
  chk_pickup_drop: assert property (cycleTick && !overV[0] && relV[0] |=> !st_q.stg[0].pickup)
    else $error("pick-up held below the reset ratio");
  chk_start_gate: assert property (st_q.stg[0].start |-> st_q.stg[0].pickup && !st_q.stg[0].blocked)
    else $error("start without pick-up or while blocked");
  chk_tick_only: assert property (!cycleTick |=> $stable(st_q.stg[0].start) && $stable(st_q.stg[0].blocked))
    else $error("stage state changed between program cycles");
  chk_blocked_raise: assert property (cycleTick && overV[0] && blk0 && !off0
    |=> st_q.stg[0].blocked && !st_q.stg[0].start && st_q.stg[0].timer == 24'h00_0000)
    else $error("blocked pick-up did not raise blocked");
  chk_start_drop: assert property (cycleTick && st_q.stg[0].start && blockIn
    |=> !st_q.stg[0].start && !st_q.stg[0].trip)
    else $error("start survived blocking");
  chk_notify_pulse: assert property ($rose(st_q.stg[0].blocked) |-> hmiNotify[0] ##1 !hmiNotify[0])
    else $error("blocked entry without one-cycle notify");
  chk_trip_fixed: assert property (cycleTick && st_q.stg[0].start && !st_q.stg[0].inv && !blk0 && !off0
    && (overV[0] || !relV[0]) && st_q.stg[0].timer + 24'h00_0001 >= st_q.stg[0].delay
    |=> st_q.stg[0].trip)
    else $error("fixed delay expired without trip");
  chk_trip_start: assert property (st_q.stg[0].trip |-> st_q.stg[0].start)
    else $error("trip without start");
  chk_event_start: assert property ($rose(st_q.stg[0].start) && st_q.stg[0].evtOn[0]
    |-> ##[0:6] (events[0].valid && events[0].sig == SIG_START && events[0].on))
    else $error("start on event not issued");
  chk_log_count: assert property (int'(st_q.stg[0].logCount) <= LOG_ENTRIES)
    else $error("log count beyond depth");
  chk_cond_trip: assert property (st_q.stg[0].trip |-> st_q.stg[0].cond == COND_TRIP)
    else $error("condition code not trip");
  chk_remain_range: assert property ($signed(st_q.stg[0].remain) <= REMAIN_LIMIT
    && $signed(st_q.stg[0].remain) >= -REMAIN_LIMIT)
    else $error("remaining time out of range");
  chk_ratio_pub: assert property (cycleTick |=> st_q.stg[0].ratio == $past(ratioV[0]))
    else $error("ratio not published");

  cov_start: cover property ($rose(st_q.stg[0].start));
  cov_trip: cover property ($rose(st_q.stg[0].trip));
  cov_blocked: cover property ($rose(st_q.stg[0].blocked));
  cov_log_full: cover property (int'(st_q.stg[0].logCount) == LOG_ENTRIES && logWr[0]);

endmodule

/* pkg/harm_oc_pkg.sv */
// constants, carriers and register map of the harmonic overcurrent stages
// Contract
// - per-unit pick-up 0.05..2.00 In, step 0.01, default 0.20
// - percent pick-up 5..200 %, step 0.01, default 20
// - per-phase ratio magnitude to threshold every cycle
// - one threshold; any phase over raises pick-up
// - pick-up drops below 97 % of threshold
// - start only while blocking inactive
// - blocking sampled at each program cycle start
// - blocked pick-up gives BLOCKED, no trip timing
// - blocking drops active start, timer released
// - entering blocked gives notify and block event
// - fixed or inverse trip delay selectable
// - on/off events per edge, masks select storage
// - four independent stages, events carry stage id
// - events carry time stamp and process data
// - twelve-entry circular log overwrites oldest
// - log on ON edges with listed fields
// - condition code 0 normal 1 start 2 trip 3 blocked
// - remaining time, 5 ms steps, within 1800 s
// - behaviour code 1 on .. 5 off
// - per-unit or relative-to-fundamental monitoring selectable
// - pre-fault value 20 ms average from -20 ms
package harm_oc_pkg;
  localparam int          NUM_STAGES     = 4;
  localparam int          LOG_DEPTH      = 12;
  localparam int          PROG_CYCLE_US  = 5000;
  localparam int          PRE_AVG_MS     = 20;
  localparam int          PRE_HIST_MS    = 200;
  localparam int          PRE_AVG_CYC    = PRE_AVG_MS * 1000 / PROG_CYCLE_US;
  localparam int          PRE_HIST_CYC   = PRE_HIST_MS * 1000 / PROG_CYCLE_US;
  localparam int          REMAIN_LIMIT_S = 1800;
  localparam int          REMAIN_LIMIT   = REMAIN_LIMIT_S * 1000000 / PROG_CYCLE_US;
  localparam logic [15:0] PU_MIN         = 16'h0005;
  localparam logic [15:0] PU_MAX         = 16'h00C8;
  localparam logic [15:0] PU_DEF         = 16'h0014;
  localparam logic [15:0] PCT_MIN        = 16'h01F4;
  localparam logic [15:0] PCT_MAX        = 16'h4E20;
  localparam logic [15:0] PCT_DEF        = 16'h07D0;
  localparam logic [31:0] PCT_SCALE      = 32'h0000_2710;
  localparam logic [31:0] RATIO_SCALE    = 32'h0000_0064;
  localparam logic [31:0] RESET_RATIO    = 32'h0000_0061;
  localparam logic [23:0] DELAY_DEF      = 24'h00_0014;
  localparam logic [23:0] SAT24          = 24'hFF_FFFF;
  // register map, one 64-byte window per stage
  localparam int          STAGE_SHIFT    = 6;
  localparam logic [5:0]  OFS_CTRL       = 6'h00;
  localparam logic [5:0]  OFS_THR_PU     = 6'h04;
  localparam logic [5:0]  OFS_THR_PCT    = 6'h08;
  localparam logic [5:0]  OFS_DELAY      = 6'h0C;
  localparam logic [5:0]  OFS_STATUS     = 6'h10;
  localparam logic [5:0]  OFS_RATIO      = 6'h14;
  localparam logic [5:0]  OFS_REMAIN     = 6'h18;
  localparam logic [5:0]  OFS_LOG_SEL    = 6'h1C;
  localparam logic [5:0]  OFS_LOG_STAMP  = 6'h20;
  localparam logic [5:0]  OFS_LOG_INFO   = 6'h24;
  localparam logic [5:0]  OFS_LOG_CURR   = 6'h28;
  localparam logic [5:0]  OFS_LOG_PRE    = 6'h2C;
  localparam logic [5:0]  OFS_LOG_REM    = 6'h30;
  // codes
  localparam logic [1:0]  COND_NORMAL    = 2'h0;
  localparam logic [1:0]  COND_START     = 2'h1;
  localparam logic [1:0]  COND_TRIP      = 2'h2;
  localparam logic [1:0]  COND_BLOCKED   = 2'h3;
  localparam logic [2:0]  BEH_ON         = 3'h1;
  localparam logic [2:0]  BEH_BLOCKED    = 3'h2;
  localparam logic [2:0]  BEH_TESTBLK    = 3'h4;
  localparam logic [2:0]  BEH_OFF        = 3'h5;
  localparam logic [1:0]  SIG_START      = 2'h0;
  localparam logic [1:0]  SIG_TRIP       = 2'h1;
  localparam logic [1:0]  SIG_BLOCK      = 2'h2;

  typedef struct packed {
    logic [2:0][15:0] harm;
    logic [2:0][15:0] fund;
  } meas_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  stageId;
    logic [1:0]  sig;
    logic        on;
    logic [31:0] stamp;
    logic [15:0] data;
  } event_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0]  sig;
    logic [2:0]  faultType;
    logic [2:0]  sg;
    logic [15:0] pre20;
    logic [15:0] fault;
    logic [15:0] pre200;
    logic [23:0] remain;
  } record_t;

  typedef struct packed {
    logic [2:0]  mode;
    logic        rel;
    logic        inv;
    logic [2:0]  evtOn;
    logic [2:0]  evtOff;
    logic [15:0] thrPu;
    logic [15:0] thrPct;
    logic [23:0] delay;
    logic [3:0]  logSel;
    logic        pickup;
    logic        start;
    logic        trip;
    logic        blocked;
    logic [1:0]  cond;
    logic [23:0] timer;
    logic [23:0] target;
    logic [23:0] ratio;
    logic [23:0] remain;
    logic [2:0]  faultType;
    logic [15:0] evtData;
    logic [31:0] evtStamp;
    logic [5:0]  pend;
    logic [3:0]  logPtr;
    logic [3:0]  logCount;
    logic        notify;
  } stage_t;
endpackage

/* testbench/meas_source.sv */
// measurement front end model: program cycle strobe, magnitudes, time stamp
`timescale 1ns/10ps
module meas_source
  import harm_oc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // harmonic level of phase one
  input  wire logic [15:0] harmLevel,
  // front end outputs
  output logic             cycleTick,
  output meas_t            meas,
  output logic      [31:0] timeStamp
);
  logic [3:0] div_q;
  // ------------------------------------------------------------
  // program cycle, one strobe every 16 clocks
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_q     <= 4'h0;
      cycleTick <= 1'b0;
      timeStamp <= 32'h0;
    end else begin
      div_q     <= div_q + 4'h1;
      cycleTick <= (div_q == 4'hF);
      if (div_q == 4'hF) begin
        timeStamp <= timeStamp + 32'h5;
      end
    end
  end
  // one phase carries the harmonic, fundamentals fixed
  assign meas = '{harm: {16'h0000, 16'h0000, harmLevel}, fund: {3{16'h0064}}};
endmodule

/* testbench/harmonic_overcurrent_stage_tb.sv */
// self-checking bench for the four harmonic overcurrent stages
`timescale 1ns/10ps
module harmonic_overcurrent_stage_tb;
  import harm_oc_pkg::*;
  logic ref_clk, sys_rst, hsel, hwrite, blockIn;
  logic [31:0] haddr, hwdata, hrdata, timeStamp, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, cycleTick;
  logic [15:0] harmLevel;
  meas_t meas;
  logic [3:0] startOut, tripOut, blockedOut, hmiNotify;
  event_t [3:0] events;
  int fails, samples_checked;
  meas_source src (.ref_clk(ref_clk), .sys_rst(sys_rst), .harmLevel(harmLevel),
    .cycleTick(cycleTick), .meas(meas), .timeStamp(timeStamp));
  harm_oc_stages uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cycleTick(cycleTick),
    .meas(meas), .blockIn(blockIn), .timeStamp(timeStamp), .settingGroup(3'h1),
    .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
    .hmiNotify(hmiNotify), .events(events));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin fails++; final_report(); end
  endtask
  task automatic tick();
    int n;
    n = 0;
    #1;
    while (cycleTick !== 1'b1 && n < 40) begin @(posedge ref_clk); #1; n++; end
    if (n >= 40) begin fails++; final_report(); end
    @(posedge ref_clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_regs();
    ahb(0, 32'h0, 0); chk(rd, 32'h0000_07E1);
    ahb(0, 32'h4, 0); chk(rd, 32'h14);
    ahb(0, 32'h8, 0); chk(rd, 32'h7D0);
    ahb(0, 32'h100, 0); chk(rd, 32'h0); chk(hresp, 1'b0);
    ahb(1, 32'h100, 32'h5); ahb(0, 32'h0, 0); chk(rd, 32'h0000_07E1);
    ahb(1, 32'h4, 32'h1); ahb(0, 32'h4, 0); chk(rd, 32'h5);
    ahb(1, 32'h4, 32'h14); ahb(1, 32'hC, 32'h100);
    $display("test regs done");
  endtask
  task automatic test_pickup();
    harmLevel <= 16'h15; tick();
    chk(startOut, 4'hF);
    @(posedge ref_clk); #1;
    chk({events[0].valid, events[0].sig, events[0].on}, 4'h9);
    ahb(0, 32'h10, 0); chk(rd[1:0], COND_START);
    harmLevel <= 16'h14; tick(); chk(startOut, 4'hF);
    harmLevel <= 16'h13; tick(); chk(startOut, 4'h0);
    $display("test pickup done");
  endtask
  task automatic test_trip();
    ahb(1, 32'hC, 32'h2);
    harmLevel <= 16'h20; tick(); tick(); chk(tripOut, 4'h0);
    tick(); chk(tripOut, 4'h1);
    ahb(0, 32'h10, 0); chk(rd[1:0], COND_TRIP);
    ahb(0, 32'h14, 0); chk(rd, 32'hA0);
    harmLevel <= 16'h0; tick(); chk(tripOut, 4'h0);
    $display("test trip done");
  endtask
  task automatic test_block();
    ahb(1, 32'hC, 32'h100);
    harmLevel <= 16'h20; tick(); chk(startOut, 4'hF);
    blockIn <= 1'b1; tick();
    chk(hmiNotify, 4'hF);
    chk(startOut, 4'h0);
    chk(blockedOut, 4'hF);
    ahb(0, 32'h10, 0); chk(rd[1:0], COND_BLOCKED);
    harmLevel <= 16'h0; blockIn <= 1'b0; tick(); chk(blockedOut, 4'h0);
    ahb(0, 32'h1C, 0); chk(rd, 32'h50);
    ahb(0, 32'h24, 0); chk(rd, 32'h26);
    ahb(0, 32'h28, 0); chk(rd[15:0], 16'h20);
    $display("test block done");
  endtask
  task automatic test_modes();
    ahb(1, 32'h0, 32'h7E5);
    harmLevel <= 16'h20; tick(); chk(startOut, 4'hE);
    ahb(1, 32'h0, 32'h7E2); tick();
    chk(blockedOut, 4'h1);
    chk(startOut, 4'hE);
    ahb(1, 32'h8, 32'h3E8); ahb(1, 32'h0, 32'h7E9);
    harmLevel <= 16'h10; tick(); chk(startOut, 4'h1);
    ahb(0, 32'h14, 0); chk(rd, 32'hA0);
    ahb(1, 32'hC, 32'h3); ahb(1, 32'h0, 32'h7F9); tick();
    ahb(0, 32'h18, 0); chk(rd, 32'h4);
    $display("test modes done");
  endtask
  initial begin
    fails = 0; samples_checked = 0;
    sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; blockIn = 1'b0; harmLevel = 16'h0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    test_regs();
    test_pickup();
    test_trip();
    test_block();
    test_modes();
    final_report();
  end
endmodule
